// File: dv/pll_serdes_trigger_config_regs_tb_top.sv
// Self-checking bench for the PLL, serializer and trigger configuration registers
`timescale 1ns/1ps
`default_nettype none
module pll_serdes_trigger_config_regs_tb_top;
    typedef struct {
        logic [14:0] addr;
        logic [7:0]  wdat;
        logic [5:0]  pins;
        logic [7:0]  rexp;
        logic [22:0] exp;
    } row_type;

    localparam int LIMIT = 60000;

    logic        sys_clk, resetn, spiCsN, spiClk, spiDataIn, spiDataOut, spiDataOutEn;
    logic        pinPllEnable, pinSingleEndedRef, pllEnable, singleEndedRefSelect;
    logic [1:0]  pinFirstRefMode, pinSecondRefMode, firstRefOutputMode, secondRefOutputMode;
    logic [6:0]  oscillatorBiasLevel;
    logic [3:0]  lanePreemphasis;
    logic        triggerOutputEnable, triggerFromSerializer, triggerFromTimestamp;
    logic [2:0]  triggerOutputMode;
    logic [22:0] outVec;
    logic [7:0]  rd;
    row_type     rows [10];
    int          error_cnt, checks_done, i, m;
    int          cycleCnt = 0;

    assign outVec = {oscillatorBiasLevel, lanePreemphasis, triggerOutputEnable, triggerOutputMode,
                     triggerFromSerializer, triggerFromTimestamp, pllEnable,
                     singleEndedRefSelect, firstRefOutputMode, secondRefOutputMode};

    pll_serdes_trigger_config_regs uut (
        .sys_clk               (sys_clk),
        .resetn                (resetn),
        .spiCsN                (spiCsN),
        .spiClk                (spiClk),
        .spiDataIn             (spiDataIn),
        .spiDataOut            (spiDataOut),
        .spiDataOutEn          (spiDataOutEn),
        .pinPllEnable          (pinPllEnable),
        .pinSingleEndedRef     (pinSingleEndedRef),
        .pinFirstRefMode       (pinFirstRefMode),
        .pinSecondRefMode      (pinSecondRefMode),
        .oscillatorBiasLevel   (oscillatorBiasLevel),
        .lanePreemphasis       (lanePreemphasis),
        .triggerOutputEnable   (triggerOutputEnable),
        .triggerOutputMode     (triggerOutputMode),
        .triggerFromSerializer (triggerFromSerializer),
        .triggerFromTimestamp  (triggerFromTimestamp),
        .pllEnable             (pllEnable),
        .singleEndedRefSelect  (singleEndedRefSelect),
        .firstRefOutputMode    (firstRefOutputMode),
        .secondRefOutputMode   (secondRefOutputMode)
    );

    // ****************************************
    // Clock, timeout and report
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == LIMIT) begin
            error_cnt++;
            $display("wrong value timeout expected finish seen hang");
            give_verdict();
        end
    end

    task give_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // ****************************************
    // Serial frame: slow clock, MSB first
    // ****************************************
    task automatic xfer(input logic rdWr, input logic [14:0] addr, input logic [7:0] wdat,
                        input int nBits, output logic [7:0] rdat);
        logic [23:0] frame;
        int          b;
        frame = {rdWr, addr, wdat};
        rdat  = 8'h00;
        @(posedge sys_clk);
        spiCsN <= 1'b0;
        repeat (6) @(posedge sys_clk);
        for (b = 23; b >= 24 - nBits; b--) begin
            spiDataIn <= frame[b];
            repeat (8) @(posedge sys_clk);
            if (b < 8) begin
                rdat[b] = spiDataOut;
                chk("dataOutEn", {22'h0, rdWr}, {22'h0, spiDataOutEn});
            end
            spiClk <= 1'b1;
            repeat (6) @(posedge sys_clk);
            spiClk <= 1'b0;
        end
        repeat (6) @(posedge sys_clk);
        spiCsN <= 1'b1;
        repeat (10) @(posedge sys_clk);
    endtask : xfer

    task automatic check_resets;
        logic [7:0]  val;
        logic [14:0] addrs [4];
        logic [7:0]  rsts  [4];
        int          k;
        addrs = '{15'h003F, 15'h0048, 15'h0057, 15'h0058};
        rsts  = '{8'h4F, 8'h00, 8'h00, 8'h00};
        for (k = 0; k < 4; k++) begin
            xfer(1'b1, addrs[k], 8'h00, 24, val);
            chk("resetRead", {15'h0000, rsts[k]}, {15'h0000, val});
        end
    endtask : check_resets

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        resetn = 1'b0;
        spiCsN = 1'b1;
        spiClk = 1'b0;
        spiDataIn = 1'b0;
        {pinPllEnable, pinSingleEndedRef, pinFirstRefMode, pinSecondRefMode} = 6'h00;
        error_cnt = 0;
        checks_done = 0;
        // bias 0x4A first, reserved bits zero
        rows[0] = '{15'h003F, 8'h4A, 6'h06, 8'h4A, {7'h4A, 4'h0, 6'h00, 6'h06}};
        rows[1] = '{15'h0048, 8'h0F, 6'h33, 8'h0F, {7'h4A, 4'hF, 6'h00, 6'h30}};
        rows[2] = '{15'h0058, 8'h8D, 6'h19, 8'h8D, {7'h4A, 4'hF, 6'h00, 6'h2C}};
        rows[3] = '{15'h0058, 8'hB6, 6'h20, 8'hB6, {7'h4A, 4'hF, 6'h00, 6'h17}};
        rows[4] = '{15'h0058, 8'hB2, 6'h20, 8'hB2, {7'h4A, 4'hF, 6'h00, 6'h10}};
        rows[5] = '{15'h0058, 8'h36, 6'h2B, 8'h36, {7'h4A, 4'hF, 6'h00, 6'h2B}};
        rows[6] = '{15'h003F, 8'h7F, 6'h2B, 8'h7F, {7'h7F, 4'hF, 6'h00, 6'h2B}};
        rows[7] = '{15'h0040, 8'h55, 6'h2B, 8'h00, {7'h7F, 4'hF, 6'h00, 6'h2B}};
        rows[8] = '{15'h0048, 8'h05, 6'h2B, 8'h05, {7'h7F, 4'h5, 6'h00, 6'h2B}};
        rows[9] = '{15'h003F, 8'h00, 6'h2B, 8'h00, {7'h00, 4'h5, 6'h00, 6'h2B}};
        repeat (3) @(posedge sys_clk);
        chk("resetOutputs", {7'h4F, 16'h0000}, outVec);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check_resets();
        for (i = 0; i < 10; i++) begin
            {pinPllEnable, pinSingleEndedRef, pinFirstRefMode, pinSecondRefMode} <= rows[i].pins;
            xfer(1'b0, rows[i].addr, rows[i].wdat, 24, rd);
            xfer(1'b1, rows[i].addr, 8'h00, 24, rd);
            chk("readBack", {15'h0000, rows[i].rexp}, {15'h0000, rd});
            chk("outputs", rows[i].exp, outVec);
        end
        for (m = 0; m < 8; m++) begin
            xfer(1'b0, 15'h0057, {5'h00, m[2:0]}, 24, rd);
            xfer(1'b0, 15'h0057, {5'h10, m[2:0]}, 24, rd);
            chk("trigger", {7'h00, 4'h5, 1'b1, m[2:0], m < 3, m == 3, 6'h2B}, outVec);
            xfer(1'b0, 15'h0057, {5'h00, m[2:0]}, 24, rd);
        end
        chk("triggerOff", {7'h00, 4'h5, 1'b0, 3'h7, 2'h0, 6'h2B}, outVec);
        // Frame cut after twenty bits
        xfer(1'b0, 15'h0048, 8'h0A, 20, rd);
        chk("abortedFrame", {7'h00, 4'h5, 1'b0, 3'h7, 2'h0, 6'h2B}, outVec);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("midReset", {7'h4F, 16'h0000}, outVec);
        resetn <= 1'b1;
        repeat (12) @(posedge sys_clk);
        chk("pinsAfterReset", {7'h4F, 4'h0, 6'h00, 6'h2B}, outVec);
        check_resets();
        give_verdict();
    end
endmodule : pll_serdes_trigger_config_regs_tb_top
`default_nettype wire

// File: logic/pll_serdes_trigger_config_regs.sv
// Serial-port register slice for PLL bias, pre-emphasis, trigger output and PLL override
`timescale 1ns/1ps
`default_nettype none
module pll_serdes_trigger_config_regs (
    input  wire logic       sys_clk,           // 40 MHz control clock
    input  wire logic       resetn,            // Async reset, active low
    input  wire logic       spiCsN,            // Serial port select, active low
    input  wire logic       spiClk,            // Serial port clock
    input  wire logic       spiDataIn,         // Serial data into device
    output var  logic       spiDataOut,        // Serial read data
    output var  logic       spiDataOutEn,      // High while driving read data
    input  wire logic       pinPllEnable,      // PLL enable strap pin
    input  wire logic       pinSingleEndedRef, // Reference select strap pin
    input  wire logic [1:0] pinFirstRefMode,   // First ref output mode from pins
    input  wire logic [1:0] pinSecondRefMode,  // Second ref output mode from pins
    output var  logic [6:0] oscillatorBiasLevel,   // Oscillator bias
    output var  logic [3:0] lanePreemphasis,       // Global lane pre-emphasis
    output var  logic       triggerOutputEnable,   // Trigger buffer/divider on
    output var  logic [2:0] triggerOutputMode,     // Trigger output mode
    output var  logic       triggerFromSerializer, // Trigger is serializer clock
    output var  logic       triggerFromTimestamp,  // Trigger is resampled timestamp
    output var  logic       pllEnable,             // Effective PLL enable
    output var  logic       singleEndedRefSelect,  // Effective reference select
    output var  logic [1:0] firstRefOutputMode,    // Effective first ref mode
    output var  logic [1:0] secondRefOutputMode    // Effective second ref mode
);
    localparam int NIN = 9;
    localparam logic [NIN-1:0] FILT_RST = 9'h100;

    // ************************************************
    // Pin input filtering
    // ************************************************
    logic [NIN-1:0] rawIn;
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    logic [NIN-1:0] sync3_r;
    logic [NIN-1:0] filt_r;
    assign rawIn = {spiCsN, spiClk, spiDataIn, pinPllEnable, pinSingleEndedRef,
                    pinFirstRefMode, pinSecondRefMode};
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    sync1_r[gi] <= FILT_RST[gi];
                    sync2_r[gi] <= FILT_RST[gi];
                    sync3_r[gi] <= FILT_RST[gi];
                    filt_r[gi]  <= FILT_RST[gi];
                end else begin
                    sync1_r[gi] <= rawIn[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        filt_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate
    logic       csN;
    logic       sclk;
    logic       sdi;
    logic       pinPllEn;
    logic       pinSeRef;
    logic [1:0] pinFirst;
    logic [1:0] pinSecond;
    assign {csN, sclk, sdi, pinPllEn, pinSeRef, pinFirst, pinSecond} = filt_r;

    // ************************************************
    // Serial frame engine
    // ************************************************
    logic                               sclkPrev_r;
    logic [4:0]                         bitCnt_r;
    logic [pll_cfg_pkg::FRAME_BITS-2:0] shiftIn_r;
    logic [7:0]                         txShift_r;
    logic [7:0]                         readData;
    logic                               sclkRise;
    logic                               sclkFall;
    logic                               rdFrame_r;
    logic                               commitWr;
    logic [14:0]                        wrAddr;
    logic [14:0]                        rdAddr;
    logic [7:0]                         wrData;
    assign sclkRise = !csN && sclk && !sclkPrev_r;
    assign sclkFall = !csN && !sclk && sclkPrev_r;
    assign rdAddr   = {shiftIn_r[pll_cfg_pkg::HEAD_BITS-3:0], sdi};
    assign wrAddr   = shiftIn_r[pll_cfg_pkg::FRAME_BITS-3 -: pll_cfg_pkg::ADDR_W];
    assign wrData   = {shiftIn_r[6:0], sdi};
    assign commitWr = sclkRise && (bitCnt_r == 5'(pll_cfg_pkg::FRAME_BITS - 1))
                      && !shiftIn_r[pll_cfg_pkg::FRAME_BITS-2];
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sclkPrev_r <= 1'b0;
            bitCnt_r   <= 5'h00;
            shiftIn_r  <= '0;
            rdFrame_r  <= 1'b0;
        end else begin
            sclkPrev_r <= sclk;
            if (csN) begin
                bitCnt_r  <= 5'h00;
                rdFrame_r <= 1'b0;
            end else if (sclkRise && bitCnt_r != 5'(pll_cfg_pkg::FRAME_BITS)) begin
                bitCnt_r  <= bitCnt_r + 5'h01;
                shiftIn_r <= {shiftIn_r[pll_cfg_pkg::FRAME_BITS-3:0], sdi};
                if (bitCnt_r == 5'(pll_cfg_pkg::HEAD_BITS - 1)) begin
                    rdFrame_r <= shiftIn_r[pll_cfg_pkg::HEAD_BITS-2];
                end
            end
        end
    end

    // ************************************************
    // Register storage
    // ************************************************
    logic [7:0] oscBias_r;
    logic [7:0] preemph_r;
    logic [7:0] trigCtrl_r;
    logic [7:0] pllOvr_r;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            oscBias_r <= pll_cfg_pkg::OSC_BIAS_RST;
        end else if (commitWr && wrAddr == pll_cfg_pkg::OSC_BIAS_ADDR) begin
            oscBias_r <= wrData;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            preemph_r <= pll_cfg_pkg::PREEMPH_RST;
        end else if (commitWr && wrAddr == pll_cfg_pkg::PREEMPH_ADDR) begin
            preemph_r <= wrData;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trigCtrl_r <= pll_cfg_pkg::TRIG_CTRL_RST;
        end else if (commitWr && wrAddr == pll_cfg_pkg::TRIG_CTRL_ADDR) begin
            trigCtrl_r <= wrData;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pllOvr_r <= pll_cfg_pkg::PLL_OVR_RST;
        end else if (commitWr && wrAddr == pll_cfg_pkg::PLL_OVR_ADDR) begin
            pllOvr_r <= wrData;
        end
    end

    // ************************************************
    // Read path
    // ************************************************
    always_comb begin
        case (rdAddr)
            pll_cfg_pkg::OSC_BIAS_ADDR:  readData = oscBias_r;
            pll_cfg_pkg::PREEMPH_ADDR:   readData = preemph_r;
            pll_cfg_pkg::TRIG_CTRL_ADDR: readData = trigCtrl_r;
            pll_cfg_pkg::PLL_OVR_ADDR:   readData = pllOvr_r;
            default:                     readData = pll_cfg_pkg::UNMAPPED_RD;
        endcase
    end
    // Read data loads after the header, shifts out on falling clock
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            txShift_r    <= 8'h00;
            spiDataOut   <= 1'b0;
            spiDataOutEn <= 1'b0;
        end else begin
            spiDataOutEn <= !csN && rdFrame_r && bitCnt_r >= 5'(pll_cfg_pkg::HEAD_BITS)
                            && bitCnt_r != 5'(pll_cfg_pkg::FRAME_BITS);
            if (csN) begin
                txShift_r  <= 8'h00;
                spiDataOut <= 1'b0;
            end else if (sclkRise && bitCnt_r == 5'(pll_cfg_pkg::HEAD_BITS - 1)) begin
                txShift_r <= readData;
            end else if (sclkFall && bitCnt_r >= 5'(pll_cfg_pkg::HEAD_BITS)) begin
                spiDataOut <= txShift_r[7];
                txShift_r  <= {txShift_r[6:0], 1'b0};
            end
        end
    end

    // ************************************************
    // Control outputs
    // ************************************************
    logic       ovrEn;
    logic [1:0] firstSel;
    logic [1:0] secondSel;
    logic [2:0] trigMode;
    assign ovrEn     = pllOvr_r[pll_cfg_pkg::OVR_EN_BIT];
    assign trigMode  = trigCtrl_r[pll_cfg_pkg::TRIG_MODE_MSB:0];
    assign firstSel  = ovrEn ? pllOvr_r[pll_cfg_pkg::FIRST_MODE_LSB +: 2] : pinFirst;
    assign secondSel = ovrEn ? pllOvr_r[pll_cfg_pkg::SECOND_MODE_LSB +: 2] : pinSecond;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            oscillatorBiasLevel <= pll_cfg_pkg::OSC_BIAS_RST[6:0];
            lanePreemphasis     <= pll_cfg_pkg::PREEMPH_RST[3:0];
        end else begin
            oscillatorBiasLevel <= oscBias_r[pll_cfg_pkg::BIAS_MSB:0];
            lanePreemphasis     <= preemph_r[pll_cfg_pkg::PREEMPH_MSB:0];
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            triggerOutputEnable   <= 1'b0;
            triggerOutputMode     <= pll_cfg_pkg::TRIG_UI16;
            triggerFromSerializer <= 1'b0;
            triggerFromTimestamp  <= 1'b0;
        end else begin
            triggerOutputEnable   <= trigCtrl_r[pll_cfg_pkg::TRIG_EN_BIT];
            triggerOutputMode     <= trigMode;
            triggerFromSerializer <= trigCtrl_r[pll_cfg_pkg::TRIG_EN_BIT]
                                     && trigMode <= pll_cfg_pkg::TRIG_UI64;
            triggerFromTimestamp  <= trigCtrl_r[pll_cfg_pkg::TRIG_EN_BIT]
                                     && trigMode == pll_cfg_pkg::TRIG_TIMESTAMP;
        end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pllEnable            <= 1'b0;
            singleEndedRefSelect <= 1'b0;
            firstRefOutputMode   <= pll_cfg_pkg::REF_OFF;
            secondRefOutputMode  <= pll_cfg_pkg::REF_OFF;
        end else begin
            pllEnable            <= ovrEn ? pllOvr_r[pll_cfg_pkg::PLL_EN_BIT] : pinPllEn;
            singleEndedRefSelect <= ovrEn ? pllOvr_r[pll_cfg_pkg::SE_REF_BIT] : pinSeRef;
            firstRefOutputMode   <= firstSel;
            secondRefOutputMode  <= (firstSel == pll_cfg_pkg::REF_OFF) ?
                                    pll_cfg_pkg::REF_OFF : secondSel;
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    sequence biasWrite;
        commitWr && wrAddr == pll_cfg_pkg::OSC_BIAS_ADDR;
    endsequence
    sequence preemphWrite;
        commitWr && wrAddr == pll_cfg_pkg::PREEMPH_ADDR;
    endsequence
    sequence trigWrite;
        commitWr && wrAddr == pll_cfg_pkg::TRIG_CTRL_ADDR;
    endsequence
    bias_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        biasWrite |-> ##2 oscillatorBiasLevel == $past(wrData[6:0], 2))
        else $error("bias output does not follow write");
    preemph_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        preemphWrite |-> ##2 lanePreemphasis == $past(wrData[3:0], 2))
        else $error("pre-emphasis output does not follow write");
    trig_enable_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        trigWrite |-> ##2 triggerOutputEnable == $past(wrData[7], 2))
        else $error("trigger enable does not follow write");
    trig_timestamp_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        triggerFromTimestamp |-> triggerOutputEnable
            && triggerOutputMode == pll_cfg_pkg::TRIG_TIMESTAMP)
        else $error("timestamp source without mode 3");
    trig_serial_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        triggerOutputEnable && triggerOutputMode <= pll_cfg_pkg::TRIG_UI64
            |-> triggerFromSerializer && !triggerFromTimestamp)
        else $error("serializer source missing");
    ovr_value_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $past(pllOvr_r[7]) |-> pllEnable == $past(pllOvr_r[0])
            && singleEndedRefSelect == $past(pllOvr_r[1]))
        else $error("override values not applied");
    pin_mode_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !pllOvr_r[7] ##1 !pllOvr_r[7] |-> pllEnable == $past(pinPllEn)
            && firstRefOutputMode == $past(pinFirst))
        else $error("pin control not applied");
    first_ref_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $past(pllOvr_r[7]) |-> firstRefOutputMode == $past(pllOvr_r[3:2]))
        else $error("first reference mode wrong");
    second_ref_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        secondRefOutputMode != pll_cfg_pkg::REF_OFF
            |-> firstRefOutputMode != pll_cfg_pkg::REF_OFF)
        else $error("second reference runs without first");
endmodule : pll_serdes_trigger_config_regs
`default_nettype wire

// File: pkg/pll_cfg_pkg.sv
// Constants for the PLL, serializer and trigger configuration registers
`default_nettype none
package pll_cfg_pkg;
    // ************************************************
    // Serial control frame
    // ************************************************
    localparam int ADDR_W     = 15;
    localparam int DATA_W     = 8;
    localparam int FRAME_BITS = 24;
    localparam int HEAD_BITS  = 16;
    localparam int RW_POS     = 23;
    localparam int SYNC_DEPTH = 3;

    // ************************************************
    // Register offsets
    // ************************************************
    localparam logic [14:0] OSC_BIAS_ADDR   = 15'h003F;
    localparam logic [14:0] PREEMPH_ADDR    = 15'h0048;
    localparam logic [14:0] TRIG_CTRL_ADDR  = 15'h0057;
    localparam logic [14:0] PLL_OVR_ADDR    = 15'h0058;

    // ************************************************
    // Reset values
    // ************************************************
    localparam logic [7:0] OSC_BIAS_RST  = 8'h4F;
    localparam logic [7:0] PREEMPH_RST   = 8'h00;
    localparam logic [7:0] TRIG_CTRL_RST = 8'h00;
    localparam logic [7:0] PLL_OVR_RST   = 8'h00;
    localparam logic [7:0] UNMAPPED_RD   = 8'h00;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int BIAS_MSB        = 6;
    localparam int PREEMPH_MSB     = 3;
    localparam int TRIG_EN_BIT     = 7;
    localparam int TRIG_MODE_MSB   = 2;
    localparam int OVR_EN_BIT      = 7;
    localparam int SECOND_MODE_LSB = 4;
    localparam int FIRST_MODE_LSB  = 2;
    localparam int SE_REF_BIT      = 1;
    localparam int PLL_EN_BIT      = 0;

    // ************************************************
    // Mode codes
    // ************************************************
    localparam logic [2:0] TRIG_UI16      = 3'h0;
    localparam logic [2:0] TRIG_UI32      = 3'h1;
    localparam logic [2:0] TRIG_UI64      = 3'h2;
    localparam logic [2:0] TRIG_TIMESTAMP = 3'h3;
    localparam logic [1:0] REF_OFF        = 2'h0;
    localparam logic [1:0] REF_DIV1       = 2'h1;
    localparam logic [1:0] REF_DIV2       = 2'h2;
    localparam logic [1:0] REF_DIV4       = 2'h3;
endpackage : pll_cfg_pkg
`default_nettype wire
